// File: bench/atf_frame_checker_properties.sv
// Purpose: Port checks for the frame formatter
// Assumes: One clock, asynchronous active-low reset
// Notes: Accepted words are counted in helper logic
`timescale 1ns/1ps
`include "atf_consts.vh"
module atf_frame_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire tx_valid,
	input wire tx_ready,
	input wire [7:0] tx_data,
	input wire tx_first,
	input wire tx_last
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg [7:0] cnt_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 8'h00;
		else if (tx_valid && tx_ready)
			cnt_q <= (cnt_q == `ATF_LAST_IDX) ? 8'h00 : cnt_q + 8'h01;
	end
	sequence start_wr;
		psel && penable && pwrite && paddr == 32'h0 && pstrb[0] && pwdata[0] && !tx_valid;
	endsequence
	sequence last_acc;
		tx_valid && tx_ready && tx_last;
	endsequence
	data_hold_a: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable({tx_data, tx_first, tx_last})) else $error("word changed in stall");
	first_word_a: assert property (tx_valid |-> tx_first == (cnt_q == 8'h00))
		else $error("first flag misplaced");
	last_word_a: assert property (tx_valid |-> tx_last == (cnt_q == `ATF_LAST_IDX))
		else $error("last flag misplaced");
	frame_gap_a: assert property (last_acc |=> !tx_valid) else $error("no gap after frame");
	no_hole_a: assert property (tx_valid && !(tx_ready && tx_last) |=> tx_valid)
		else $error("frame broken off");
	idle_count_a: assert property (!tx_valid |-> cnt_q == 8'h00) else $error("short frame");
	start_frame_a: assert property (start_wr |=> tx_valid && tx_first) else $error("no start");
	zero_wait_a: assert property (psel && penable |-> pready) else $error("wait state");
	bad_addr_a: assert property (psel && penable && !pwrite && paddr[1:0] != 2'b00 |->
		pslverr && prdata == 32'h0) else $error("misaligned read accepted");
endmodule
bind atf_frame_formatter atf_frame_checker atf_frame_checker_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last));

// File: bench/atf_sink.sv
// Purpose: Telemetry unit port model that takes frame words
// Assumes: Words taken on tx_valid and tx_ready at a rising edge
// Notes: With slow set it stalls on three edges in four at random
`timescale 1ns/1ps
module atf_sink (
	input wire pclk,
	input wire presetn,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_first,
	input wire tx_last,
	input wire slow,
	output reg tx_ready
);
	reg [7:0] words [0:223];
	reg [7:0] n_q;
	integer frames_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_q <= 8'h00;
			frames_q <= 0;
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
			if (tx_valid && tx_ready) begin
				words[tx_first ? 8'h00 : n_q] <= tx_data;
				n_q <= tx_first ? 8'h01 : n_q + 8'h01;
				if (tx_last)
					frames_q <= frames_q + 1;
			end
		end
	end
endmodule

// File: bench/test_aspect_telemetry_frame_formatter.sv
// Purpose: Random frames checked word by word against a bench model
// Assumes: Content is written before each start and left alone meanwhile
// Notes: Image k carries array type k, so every type code is sent
`timescale 1ns/1ps
module test_aspect_telemetry_frame_formatter;
	reg pclk, presetn, psel, penable, pwrite, slow, erv;
	reg [31:0] paddr, pwdata, rdv;
	reg [3:0] pstrb;
	wire pready, pslverr, tx_valid, tx_ready, tx_first, tx_last;
	wire [31:0] prdata;
	wire [7:0] tx_data;
	reg [31:0] itime, hdr, temp;
	reg [31:0] ir [0:39];
	reg [9:0] pix [0:127];
	reg [0:1791] ex;
	integer bp, f, k, j, fr, err_count, num_checks, cyc;
	atf_frame_formatter atf_frame_formatter_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last));
	atf_sink atf_sink_i (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_first(tx_first), .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready));
	always #5 pclk = ~pclk;
	task close_out;
		begin
			$display("checks %0d mismatches %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			err_count = err_count + 1;
			close_out;
		end
	end
	task chk(input [31:0] got, input [31:0] want);
		begin
			num_checks = num_checks + 1;
			if (got !== want) begin
				err_count = err_count + 1;
				$display("wrong value at %0t: got %h want %h", $time, got, want);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= {20'h0, a};
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rdv = prdata;
			erv = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	function void push(input [31:0] v, input integer w);
		for (int i = w - 1; i >= 0; i--) begin
			ex[bp] = v[i];
			bp = bp + 1;
		end
	endfunction
	function void build();
		reg [31:0] c, rw, cl;
		reg [2:0] t;
		bp = 0;
		push(itime, 16);
		push(hdr[7:0], 8);
		push(hdr[15:8], 8);
		push(hdr[23:16], 8);
		for (int g = 0; g < 8; g++)
			push(ir[g * 5][3:1], 3);
		for (int g = 0; g < 8; g++) begin
			c = ir[g * 5];
			t = c[3:1];
			push({c[0], c[6:4], c[8:7]}, 6);
			rw = c[15] ? ir[g * 5 + 1][19:10] : ir[g * 5 + 4][19:10] - (t == 3'h4 ? 4 : 2);
			cl = c[15] ? ir[g * 5 + 1][9:0] : ir[g * 5 + 4][9:0] - (t == 3'h4 ? 4 : 2);
			if (t == 3'h0 || t == 3'h1 || t == 3'h4) begin
				push(c[14:9], 6);
				push(rw, 10);
				push(cl, 10);
				push(ir[g * 5 + 2], 24);
			end else if (t == 3'h2 || t == 3'h5) begin
				push(ir[g * 5 + 3][17:8], 10);
				push(temp, 32);
				push(ir[g * 5 + 3][7:0], 8);
			end else begin
				push(0, 25);
				push(0, 25);
			end
			for (int p = 0; p < 16; p++)
				push((c[15] || t == 3'h3) ? pix[g * 16 + p] : 0, 10);
		end
	endfunction
	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		pstrb = 4'hf;
		slow = 0;
		err_count = 0;
		num_checks = 0;
		cyc = 0;
		k = $urandom(68);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 0);
		chk(rdv, 0);
		apb(1'b0, 12'h042, 0);
		chk(erv, 1);
		chk(rdv, 0);
		pstrb <= 4'h1;
		apb(1'b1, 12'h004, 32'hffff_ff5a);
		pstrb <= 4'hf;
		apb(1'b0, 12'h004, 0);
		chk(rdv, 32'h0000_005a);
		$display("register test done");
		for (f = 0; f < 2; f++) begin
			slow <= f[0];
			itime = $urandom & 32'hffff;
			hdr = $urandom & 32'hffffff;
			temp = $urandom;
			apb(1'b1, 12'h004, itime);
			apb(1'b1, 12'h008, hdr);
			apb(1'b1, 12'h00c, temp);
			for (k = 0; k < 8; k++) begin
				ir[k * 5] = ($urandom & 32'hfff1) | (k << 1);
				ir[k * 5 + 1] = $urandom & 32'hfffff;
				ir[k * 5 + 2] = $urandom & 32'hffffff;
				ir[k * 5 + 3] = $urandom & 32'h3ffff;
				ir[k * 5 + 4] = $urandom & (k == 0 ? 32'h3ff : 32'hfffff);
				if (k == f || k == f + 4)
					ir[k * 5][15] = 1'b0;
				for (j = 0; j < 5; j++)
					apb(1'b1, 12'h040 + k * 32 + j * 4, ir[k * 5 + j]);
				for (j = 0; j < 16; j++) begin
					pix[k * 16 + j] = (j == 15) ? 10'h3ff : $urandom;
					apb(1'b1, 12'h200 + (k * 16 + j) * 4, {22'h0, pix[k * 16 + j]});
				end
			end
			fr = atf_sink_i.frames_q;
			apb(1'b1, 12'h000, 1);
			apb(1'b0, 12'h000, 0);
			chk(rdv, (f << 16) | 2);
			apb(1'b1, 12'h000, 1);
			for (k = 0; k < 20000 && atf_sink_i.frames_q == fr; k++)
				@(posedge pclk);
			chk(atf_sink_i.frames_q, fr + 1);
			build();
			for (j = 0; j < 224; j++)
				chk(atf_sink_i.words[j], ex[j * 8 +: 8]);
			apb(1'b0, 12'h000, 0);
			chk(rdv, (f + 1) << 16);
			$display("frame test %0d done", f);
		end
		close_out;
	end
endmodule

// File: design/atf_consts.vh
// Purpose: Constants for the aspect telemetry frame formatter
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: Frame bit 0 of every word is its most significant bit
`ifndef ATF_CONSTS_VH
`define ATF_CONSTS_VH

`define ATF_FRAME_WORDS 8'd224
`define ATF_LAST_IDX 8'd223
`define ATF_HDR_WORDS 8'd8
`define ATF_GRP_WORDS 5'd27
`define ATF_LAST_WRD 5'd26
`define ATF_LAST_GRP 3'd7

`define ATF_TYPE_4X4 3'h0
`define ATF_TYPE_6X6_FIRST 3'h1
`define ATF_TYPE_6X6_SECOND 3'h2
`define ATF_TYPE_DOWNLOAD 3'h3
`define ATF_TYPE_8X8_SEG1 3'h4
`define ATF_TYPE_8X8_SEG2 3'h5
`define ATF_TYPE_8X8_SEG3 3'h6
`define ATF_TYPE_8X8_SEG4 3'h7

`define ATF_HALF_SMALL 10'h002
`define ATF_HALF_LARGE 10'h004

`define ATF_ADDR_CTRL 12'h000
`define ATF_ADDR_ITIME 12'h004
`define ATF_ADDR_HDR 12'h008
`define ATF_ADDR_TEMP 12'h00c
`define ATF_IMG_BASE 12'h040
`define ATF_IMG_TOP 12'h140
`define ATF_PIX_BASE 12'h200
`define ATF_PIX_TOP 12'h400

`define ATF_IREG_CFG 3'h0
`define ATF_IREG_POS 3'h1
`define ATF_IREG_SCALE 3'h2
`define ATF_IREG_BG 3'h3
`define ATF_IREG_CTR 3'h4

`define ATF_CFG_FID 0
`define ATF_CFG_TYPE_LSB 1
`define ATF_CFG_NUM_LSB 4
`define ATF_CFG_FUNC_LSB 7
`define ATF_CFG_STAT_LSB 9
`define ATF_CFG_FOUND 15

`define ATF_CTRL_START 0
`define ATF_CTRL_BUSY 1

`endif

// File: design/atf_frame_formatter.v
// Purpose: Builds the 224-word aspect telemetry frame and streams it out
// Assumes: Frame content is set over APB and held steady while a frame is sent
// Notes: tx_data[7] carries word bit 0, the most significant bit
// How it works
// - Frame is 224 consecutive 8-bit words
// - Words 1-2 integration time, word 3 status
// - Word 4 command count, word 5 progress
// - Words 6-8 hold per-image array-type codes
// - Codes 000 4x4, 001/010 6x6 halves
// - Codes 100-111 are 8x8 segments one-four
// - Code 011 marks memory download slot
// - Then eight 27-word groups in image order
// - Group bit 0 is fid: 1 fiducial, 0 star
// - Not found: array centred on search window
// - Not found: pixel values are zero, except in download slots (code 011)
// - Four temperature counts sent for 6x6, 8x8
// - Status then lead pixel row, column in words 2-4
// - Words 8-27 pixels packed from lead pixel on
// - 6x6 second half: rms, temperatures, pixel status
// - Integration time is 16 bits, 16 ms steps
// - Count byte: count, syntax flag, checksum flag
// - Background status bit per corner, 1 included
// - Pixels and row, column numbers are 10 bits
`timescale 1ns/1ps
`include "atf_consts.vh"

module atf_frame_formatter (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	output reg tx_valid,
	input wire tx_ready,
	output reg [7:0] tx_data,
	output reg tx_first,
	output reg tx_last
);

	// Per-image registers: cfg, lead position, scale/average, rms/outliers, window centre
	reg [15:0] img_cfg [0:7];
	reg [19:0] img_pos [0:7];
	reg [23:0] img_scale [0:7];
	reg [17:0] img_bg [0:7];
	reg [19:0] img_ctr [0:7];
	reg [9:0] pix_mem [0:127];
	reg [15:0] itime_q;
	reg [7:0] gstat_q;
	reg [7:0] ccount_q;
	reg [7:0] cprog_q;
	reg [31:0] temp_q;
	reg busy_q;
	reg [15:0] frames_q;
	reg [7:0] idx_q;
	reg [2:0] grp_q;
	reg [4:0] wrd_q;
	reg [31:0] rd_d;
	reg dec_ok;
	reg [7:0] sel_idx;
	reg [2:0] sel_grp;
	reg [4:0] sel_wrd;
	reg [63:0] hdr_vec;
	reg [215:0] grp_vec;
	reg [159:0] pix_vec;
	reg [9:0] row_v;
	reg [9:0] col_v;
	reg [7:0] byte_d;
	reg [15:0] cfg_v;
	reg [2:0] type_v;
	reg [5:0] head_v;
	integer k;
	integer n;

	wire [11:0] a = paddr[11:0];
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite & dec_ok;
	// Image blocks start two slots up; the wrap maps 0x100 and 0x120 to images 6 and 7
	wire [2:0] a_img = a[7:5] - 3'h2;
	wire [2:0] a_reg = a[4:2];
	wire [6:0] a_pix = a[8:2];
	wire in_img = (a >= `ATF_IMG_BASE) && (a < `ATF_IMG_TOP) && (a_reg <= `ATF_IREG_CTR);
	wire in_pix = (a >= `ATF_PIX_BASE) && (a < `ATF_PIX_TOP);
	wire start = wr_en && (a == `ATF_ADDR_CTRL) && pwdata[`ATF_CTRL_START] && !busy_q;
	wire advance = tx_valid && tx_ready;
	wire at_end = (idx_q == `ATF_LAST_IDX);

	// Merge write data into a register under the byte strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] st;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (st[b])
					merge[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
	endfunction

	// Array-type code held in an image's configuration word
	function [2:0] type_of;
		input [15:0] cfg;
		begin
			type_of = cfg[`ATF_CFG_TYPE_LSB +: 3];
		end
	endfunction

	// Row and column halves of a packed position word
	function [9:0] row_of;
		input [19:0] pos;
		begin
			row_of = pos[19:10];
		end
	endfunction

	function [9:0] col_of;
		input [19:0] pos;
		begin
			col_of = pos[9:0];
		end
	endfunction

	// Lead pixel of an array centred on the window; 8x8 reaches further out
	function [9:0] centre_lead;
		input [9:0] ctr;
		input [2:0] typ;
		begin
			if (typ[2])
				centre_lead = ctr - `ATF_HALF_LARGE;
			else
				centre_lead = ctr - `ATF_HALF_SMALL;
		end
	endfunction

	// No wait states; unmapped or misaligned accesses answer with an error and read zero
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~dec_ok;
	// Addressed register with the written bytes merged in
	wire [31:0] wr_val = merge(rd_d, pwdata, pstrb);

	always @* begin
		rd_d = 32'h0000_0000;
		dec_ok = 1'b1;
		if (a[1:0] != 2'b00 || paddr[31:12] != 20'h00000)
			dec_ok = 1'b0;
		else if (a == `ATF_ADDR_CTRL)
			rd_d = {frames_q, 14'h0000, busy_q, 1'b0};
		else if (a == `ATF_ADDR_ITIME)
			rd_d = {16'h0000, itime_q};
		else if (a == `ATF_ADDR_HDR)
			rd_d = {8'h00, cprog_q, ccount_q, gstat_q};
		else if (a == `ATF_ADDR_TEMP)
			rd_d = temp_q;
		else if (in_img) begin
			case (a_reg)
				`ATF_IREG_CFG: rd_d = {16'h0000, img_cfg[a_img]};
				`ATF_IREG_POS: rd_d = {12'h000, img_pos[a_img]};
				`ATF_IREG_SCALE: rd_d = {8'h00, img_scale[a_img]};
				`ATF_IREG_BG: rd_d = {14'h0000, img_bg[a_img]};
				default: rd_d = {12'h000, img_ctr[a_img]};
			endcase
		end else if (in_pix)
			rd_d = {22'h000000, pix_mem[a_pix]};
		else
			dec_ok = 1'b0;
	end

	// Read data is taken in the setup cycle so it stands through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= rd_d;
	end

	// Frame content is not snapshotted: it must stay put while a frame goes out
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			itime_q <= 16'h0000;
			gstat_q <= 8'h00;
			ccount_q <= 8'h00;
			cprog_q <= 8'h00;
			temp_q <= 32'h0000_0000;
			for (k = 0; k < 8; k = k + 1) begin
				img_cfg[k] <= 16'h0000;
				img_pos[k] <= 20'h00000;
				img_scale[k] <= 24'h000000;
				img_bg[k] <= 18'h00000;
				img_ctr[k] <= 20'h00000;
			end
		end else if (wr_en) begin
			if (a == `ATF_ADDR_ITIME)
				itime_q <= wr_val[15:0];
			if (a == `ATF_ADDR_HDR) begin
				if (pstrb[0])
					gstat_q <= pwdata[7:0];
				if (pstrb[1])
					ccount_q <= pwdata[15:8];
				if (pstrb[2])
					cprog_q <= pwdata[23:16];
			end
			if (a == `ATF_ADDR_TEMP)
				temp_q <= wr_val;
			if (in_img) begin
				case (a_reg)
					`ATF_IREG_CFG: img_cfg[a_img] <= wr_val[15:0];
					`ATF_IREG_POS: img_pos[a_img] <= wr_val[19:0];
					`ATF_IREG_SCALE: img_scale[a_img] <= wr_val[23:0];
					`ATF_IREG_BG: img_bg[a_img] <= wr_val[17:0];
					default: img_ctr[a_img] <= wr_val[19:0];
				endcase
			end
		end
	end

	// Pixel store has no reset; contents are set before a frame
	always @(posedge pclk) begin
		if (wr_en && in_pix)
			pix_mem[a_pix] <= wr_val[9:0];
	end

	// Position of the word to be loaded next
	always @* begin
		if (!busy_q) begin
			sel_idx = 8'h00;
			sel_grp = 3'h0;
			sel_wrd = 5'h00;
		end else begin
			sel_idx = idx_q + 8'h01;
			sel_grp = grp_q;
			sel_wrd = wrd_q;
			if (idx_q >= `ATF_HDR_WORDS - 8'h01) begin
				if (idx_q == `ATF_HDR_WORDS - 8'h01)
					sel_wrd = 5'h00;
				else if (wrd_q == `ATF_LAST_WRD) begin
					sel_wrd = 5'h00;
					sel_grp = grp_q + 3'h1;
				end else
					sel_wrd = wrd_q + 5'h01;
			end
		end
	end

	// Header, first field at the top; images 2 and 5 straddle two words
	always @* begin
		hdr_vec[63:40] = {itime_q, gstat_q};
		hdr_vec[39:24] = {ccount_q, cprog_q};
		hdr_vec[23:21] = type_of(img_cfg[0]);
		hdr_vec[20:18] = type_of(img_cfg[1]);
		hdr_vec[17:15] = type_of(img_cfg[2]);
		hdr_vec[14:12] = type_of(img_cfg[3]);
		hdr_vec[11:9] = type_of(img_cfg[4]);
		hdr_vec[8:6] = type_of(img_cfg[5]);
		hdr_vec[5:3] = type_of(img_cfg[6]);
		hdr_vec[2:0] = type_of(img_cfg[7]);
	end

	// Group content for the selected image
	always @* begin
		cfg_v = img_cfg[sel_grp];
		type_v = type_of(cfg_v);
		head_v = {cfg_v[`ATF_CFG_FID], cfg_v[`ATF_CFG_NUM_LSB +: 3],
			cfg_v[`ATF_CFG_FUNC_LSB +: 2]};
		if (cfg_v[`ATF_CFG_FOUND]) begin
			row_v = row_of(img_pos[sel_grp]);
			col_v = col_of(img_pos[sel_grp]);
		end else begin
			row_v = centre_lead(row_of(img_ctr[sel_grp]), type_v);
			col_v = centre_lead(col_of(img_ctr[sel_grp]), type_v);
		end
		// Download slots keep their stored words even when nothing was found
		for (n = 0; n < 16; n = n + 1) begin
			if (cfg_v[`ATF_CFG_FOUND] || type_v == `ATF_TYPE_DOWNLOAD)
				pix_vec[159 - 10*n -: 10] = pix_mem[{sel_grp, n[3:0]}];
			else
				pix_vec[159 - 10*n -: 10] = 10'h000;
		end
		case (type_v)
			`ATF_TYPE_4X4, `ATF_TYPE_6X6_FIRST, `ATF_TYPE_8X8_SEG1:
				grp_vec = {head_v, cfg_v[`ATF_CFG_STAT_LSB +: 6], row_v, col_v,
					img_scale[sel_grp], pix_vec};
			`ATF_TYPE_6X6_SECOND, `ATF_TYPE_8X8_SEG2:
				grp_vec = {head_v, img_bg[sel_grp][17:8], temp_q,
					img_bg[sel_grp][7:0], pix_vec};
			`ATF_TYPE_DOWNLOAD:
				grp_vec = {head_v, 50'h0, pix_vec};
			`ATF_TYPE_8X8_SEG3, `ATF_TYPE_8X8_SEG4:
				grp_vec = {head_v, 50'h0, pix_vec};
			default:
				grp_vec = {head_v, 50'h0, pix_vec};
		endcase
		if (sel_idx < `ATF_HDR_WORDS)
			byte_d = hdr_vec[63 - 8*sel_idx[2:0] -: 8];
		else
			byte_d = grp_vec[215 - 8*sel_wrd -: 8];
	end

	// The edge that takes the start write loads word 1; a start while busy is dropped
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			idx_q <= 8'h00;
			grp_q <= 3'h0;
			wrd_q <= 5'h00;
			frames_q <= 16'h0000;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_first <= 1'b0;
			tx_last <= 1'b0;
		end else if (start) begin
			busy_q <= 1'b1;
			idx_q <= 8'h00;
			grp_q <= 3'h0;
			wrd_q <= 5'h00;
			tx_valid <= 1'b1;
			tx_data <= byte_d;
			tx_first <= 1'b1;
			tx_last <= 1'b0;
		end else if (busy_q && advance) begin
			if (at_end) begin
				busy_q <= 1'b0;
				tx_valid <= 1'b0;
				tx_last <= 1'b0;
				frames_q <= frames_q + 16'h0001;
			end else begin
				idx_q <= sel_idx;
				grp_q <= sel_grp;
				wrd_q <= sel_wrd;
				tx_data <= byte_d;
				tx_last <= (sel_idx == `ATF_LAST_IDX);
			end
			tx_first <= 1'b0;
		end
	end

endmodule
